// *** rtl/dpt_pkg.sv ***
/*
 * Constants, register map and state types of the dual channel PWM timer.
 * Assumes a 32-bit APB master; register indices times four give byte addresses.
 */
package dpt_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_CTRL  = 10'h100;  // Count control
    localparam logic [9:0] IDX_MODE  = 10'h101;  // timer_mode_reg, buffer enables
    localparam logic [9:0] IDX_PINM  = 10'h102;  // pwm_pin_mode_reg
    localparam logic [9:0] IDX_CH0   = 10'h140;  // Channel 0 block
    localparam logic [9:0] IDX_CH1   = 10'h150;  // Channel 1 block
    localparam logic [9:0] IDX_STAT0 = 10'h143;  // ch0_status_reg
    localparam logic [9:0] IDX_STAT1 = 10'h153;  // ch1_status_reg
    localparam logic [3:0] OFS_CNT   = 4'h0;
    localparam logic [3:0] OFS_MASK  = 4'h2;
    localparam logic [3:0] OFS_STAT  = 4'h3;
    localparam logic [3:0] OFS_GRA   = 4'h4;
    localparam logic [3:0] OFS_GRB   = 4'h5;
    localparam logic [3:0] OFS_GRC   = 4'h6;
    localparam logic [3:0] OFS_GRD   = 4'h7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CF_START = 0;   // Two start bits
    localparam int CF_CSS   = 2;   // count_source_select, 3 bits
    localparam int CF_EDGE  = 5;   // ext_clock_edge_select, 2 bits
    localparam int CF_EXTEN = 7;   // ext_clock_input_enable
    localparam int MF_BFC   = 0;   // buffer_enable_c, one bit per channel
    localparam int MF_BFD   = 2;   // buffer_enable_d, one bit per channel
    localparam int SB_A     = 0;
    localparam int SB_B     = 1;
    localparam int SB_C     = 2;
    localparam int SB_D     = 3;
    localparam int SB_OVF   = 4;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0]  STAT0_RST = 8'h70;
    localparam logic [7:0]  STAT1_RST = 8'h60;
    localparam logic [7:0]  PINM_FIX  = 8'h88;  // Unassigned bits read 1
    localparam logic [15:0] GR_RST    = 16'hFFFF;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    typedef enum logic [2:0] {
        CSS_F1  = 3'b000,
        CSS_F2  = 3'b001,
        CSS_F4  = 3'b010,
        CSS_F8  = 3'b011,
        CSS_F32 = 3'b100,
        CSS_EXT = 3'b101
    } dpt_css_t;

    typedef enum logic [1:0] {
        EDG_RISE = 2'b00,
        EDG_FALL = 2'b01,
        EDG_BOTH = 2'b10
    } dpt_edge_t;

    typedef enum logic [3:0] {
        R_NONE = 4'h0, R_CTRL = 4'h1, R_MODE = 4'h2, R_PINM = 4'h3,
        R_CNT  = 4'h4, R_MASK = 4'h5, R_STAT = 4'h6, R_GRA  = 4'h7,
        R_GRB  = 4'h8, R_GRC  = 4'h9, R_GRD  = 4'hA
    } dpt_reg_t;

    typedef struct packed {
        logic [1:0]       start;
        dpt_css_t         css;
        dpt_edge_t        edge_sel;
        logic             exten;
        logic [1:0]       bfc;
        logic [1:0]       bfd;
        logic [1:0][2:0]  pwm_sel;   // b, c, d per channel
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] gra;
        logic [1:0][15:0] grb;
        logic [1:0][15:0] grc;
        logic [1:0][15:0] grd;
        logic [1:0][4:0]  flag;
        logic [1:0][4:0]  armed;     // Flags software has seen as 1
        logic [1:0][4:0]  mask;
        logic [1:0]       pb;
        logic [1:0]       pc;
        logic [1:0]       pd;
        logic [4:0]       pre;
        logic [2:0]       ext_sync;
        logic             rdy;
        logic             err;
        logic             irq;
        logic [31:0]      rdata;
    } dpt_state_t;

endpackage

// *** rtl/dpt_pwm.sv ***
/*
 * Two channel 16-bit PWM timer with compare/overflow flags, period and
 * changing-point registers, buffer mode and external count clock.
 * Assumes an APB master on pclk; the external clock pin is asynchronous.
 */
// How it works
// R1: Edge select only for external source, enabled
// R2: Period match sets compare flag A
// R3: Register B match sets compare flag B
// R4: Register C match sets flag C, buffered too
// R5: Register D match sets flag D, buffered too
// R6: Counter wrap past maximum sets overflow flag
// R7: Underflow flag does nothing in PWM
// R8: Flag clears by read-one then write-zero
// R9: Unseen flag survives a zero write
// R10: Writing one leaves a flag alone
// R11: Channel 0 status bit 5 reads one
// R12: Dead-time and pin control registers ignored
// R13: Register A sets period, drives no pin
// R14: Registers B, C, D set pin changing points
// R15: Buffered C holds next period, no pin
// R16: Buffered D holds next B changing point
// R17: Two identical channels, own counters and flags
// R18: Per-pin select: timer or PWM function
// R19: Buffers load at period match
`timescale 1ns/1ps
module dpt_pwm
    import dpt_pkg::*;
(
    input  wire logic        pclk,        // 25 MHz bus and count clock
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        ce,          // Freezes all state while low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // Unmapped address
    input  wire logic        ext_clk_pin, // External count clock pin
    output logic      [1:0]  pin_b,       // output_pin_b per channel
    output logic      [1:0]  pin_c,       // output_pin_c per channel
    output logic      [1:0]  pin_d,       // output_pin_d per channel
    output logic             irq          // Level interrupt
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Dead-time and pin control registers have no place here at all
    function automatic dpt_reg_t dpt_dec(input logic [9:0] idx);
        dpt_reg_t r;
        r = R_NONE;
        if (idx == IDX_CTRL)
            r = R_CTRL;
        else if (idx == IDX_MODE)
            r = R_MODE;
        else if (idx == IDX_PINM)
            r = R_PINM;
        else if (idx[9:5] == IDX_CH0[9:5] && idx[4:0] != 5'h00 || idx == IDX_CH0)
        begin
            case (idx[3:0])
                OFS_CNT:  r = R_CNT;
                OFS_MASK: r = R_MASK;
                OFS_STAT: r = R_STAT;
                OFS_GRA:  r = R_GRA;
                OFS_GRB:  r = R_GRB;
                OFS_GRC:  r = R_GRC;
                OFS_GRD:  r = R_GRD;
                default:  r = R_NONE;  // [R12]
            endcase
        end
        return r;
    endfunction

    // Internal prescaler tap for each count source
    function automatic logic dpt_tap(input dpt_css_t c, input logic [4:0] p);
        logic t;
        case (c)
            CSS_F1:  t = 1'h1;
            CSS_F2:  t = p[0];
            CSS_F4:  t = &p[1:0];
            CSS_F8:  t = &p[2:0];
            CSS_F32: t = &p[4:0];
            default: t = 1'h0;
        endcase
        return t;
    endfunction

    dpt_state_t s;
    dpt_state_t next_s;
    dpt_reg_t   ra;
    logic       ch;
    logic       acc;
    logic       ext_ev;
    logic       tk;

    // ----------------------------------------------------------------
    // Count tick
    // ----------------------------------------------------------------
    assign ra  = dpt_dec(paddr[11:2]);
    assign ch  = paddr[6];
    assign acc = psel & penable & s.rdy;

    // Edge choice matters only with the pin selected and enabled
    always_comb
    begin
        ext_ev = 1'h0;
        if (s.css == CSS_EXT && s.exten)  // [R1]
        begin
            case (s.edge_sel)
                EDG_FALL: ext_ev = ~s.ext_sync[1] & s.ext_sync[2];
                EDG_BOTH: ext_ev = s.ext_sync[1] ^ s.ext_sync[2];
                default:  ext_ev = s.ext_sync[1] & ~s.ext_sync[2];
            endcase
        end
        tk = ext_ev | dpt_tap(s.css, s.pre);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [31:0] rv;
        logic        ma;
        logic        mb;
        logic        mc;
        logic        md;
        rv       = 32'h0000_0000;
        ma       = 1'h0;
        mb       = 1'h0;
        mc       = 1'h0;
        md       = 1'h0;
        next_s   = s;
        next_s.rdy = 1'h0;
        next_s.err = 1'h0;
        next_s.pre = s.pre + 5'h01;
        // First stage feeds only the second
        next_s.ext_sync = {s.ext_sync[1:0], ext_clk_pin};

        // Status access: clear only what was returned as 1
        if (acc && ra == R_STAT)
        begin
            if (pwrite)
            begin
                // Zero write clears a seen flag, one write keeps it; any write disarms
                next_s.flag[ch]  = s.flag[ch] & ~(s.armed[ch] & ~pwdata[4:0]);  // [R8] [R9] [R10]
                next_s.armed[ch] = 5'h00;
            end
            else
                next_s.armed[ch] = s.rdata[4:0];  // [R8]
        end

        // Both channels run the same logic
        for (int i = 0; i < 2; i++)  // [R17]
        begin
            ma = s.cnt[i] == s.gra[i];
            mb = s.cnt[i] == s.grb[i];
            mc = s.cnt[i] == s.grc[i];
            md = s.cnt[i] == s.grd[i];
            if (s.start[i] && tk)
            begin
                // Register A only bounds the period
                if (ma)  // [R13]
                begin
                    next_s.cnt[i] = 16'h0000;
                    next_s.flag[i][SB_A] = 1'h1;  // [R2]
                    // Buffers move on the period edge only
                    if (s.bfc[i])
                        next_s.gra[i] = s.grc[i];  // [R15] [R19]
                    if (s.bfd[i])
                        next_s.grb[i] = s.grd[i];  // [R16] [R19]
                end
                else
                begin
                    next_s.cnt[i] = s.cnt[i] + 16'h0001;
                    if (s.cnt[i] == CNT_MAX)
                        next_s.flag[i][SB_OVF] = 1'h1;  // [R6]
                end
                if (mb)
                    next_s.flag[i][SB_B] = 1'h1;  // [R3]
                if (mc)
                    next_s.flag[i][SB_C] = 1'h1;  // [R4]
                if (md)
                    next_s.flag[i][SB_D] = 1'h1;  // [R5]
                // Pin low at period start, high at its changing point
                if (ma)
                begin
                    next_s.pb[i] = 1'h0;  // [R14]
                    next_s.pc[i] = 1'h0;
                    next_s.pd[i] = 1'h0;
                end
                else
                begin
                    next_s.pb[i] = s.pb[i] | mb;  // [R14]
                    next_s.pc[i] = s.pc[i] | mc;
                    next_s.pd[i] = s.pd[i] | md;
                end
            end
            // Timer-mode pins and buffer registers drive nothing
            if (!s.pwm_sel[i][0])
                next_s.pb[i] = 1'h0;  // [R18]
            if (!s.pwm_sel[i][1] || s.bfc[i])
                next_s.pc[i] = 1'h0;  // [R15] [R18]
            if (!s.pwm_sel[i][2] || s.bfd[i])
                next_s.pd[i] = 1'h0;  // [R16] [R18]
        end

        // Register writes here win over hardware updates of the same word; a flag set wins over a status clear
        if (acc && pwrite)
        begin
            case (ra)
                R_CTRL:
                begin
                    next_s.start    = pwdata[CF_START +: 2];
                    next_s.css      = dpt_css_t'(pwdata[CF_CSS +: 3]);
                    next_s.edge_sel = dpt_edge_t'(pwdata[CF_EDGE +: 2]);
                    next_s.exten    = pwdata[CF_EXTEN];
                end
                R_MODE:
                begin
                    next_s.bfc = pwdata[MF_BFC +: 2];
                    next_s.bfd = pwdata[MF_BFD +: 2];
                end
                R_PINM:
                begin
                    next_s.pwm_sel[0] = pwdata[2:0];  // [R18]
                    next_s.pwm_sel[1] = pwdata[6:4];
                end
                R_CNT:   next_s.cnt[ch]  = pwdata[15:0];
                R_MASK:  next_s.mask[ch] = pwdata[4:0];
                R_GRA:   next_s.gra[ch]  = pwdata[15:0];
                R_GRB:   next_s.grb[ch]  = pwdata[15:0];
                R_GRC:   next_s.grc[ch]  = pwdata[15:0];
                R_GRD:   next_s.grd[ch]  = pwdata[15:0];
                default: next_s.err = 1'h0;
            endcase
        end

        // Read mux; upper status bits are fixed, underflow never moves
        case (ra)
            R_CTRL:  rv = {24'h00_0000, s.exten, s.edge_sel, s.css, s.start};
            R_MODE:  rv = {28'h000_0000, s.bfd, s.bfc};
            R_PINM:  rv = {24'h00_0000, PINM_FIX | {1'h0, s.pwm_sel[1], 1'h0, s.pwm_sel[0]}};
            R_CNT:   rv = {16'h0000, s.cnt[ch]};
            R_MASK:  rv = {27'h000_0000, s.mask[ch]};
            R_STAT:  rv = {24'h00_0000, ch ? STAT1_RST[7:5] : STAT0_RST[7:5],
                           s.flag[ch]};  // [R7] [R11]
            R_GRA:   rv = {16'h0000, s.gra[ch]};
            R_GRB:   rv = {16'h0000, s.grb[ch]};
            R_GRC:   rv = {16'h0000, s.grc[ch]};
            R_GRD:   rv = {16'h0000, s.grd[ch]};
            default: rv = 32'h0000_0000;
        endcase

        // Setup cycle latches the answer; access completes one cycle later
        if (psel && !penable && !s.rdy)
        begin
            next_s.rdy   = 1'h1;
            next_s.rdata = rv;
            next_s.err   = ra == R_NONE;
        end

        // One cycle of lag is traded for a flop-driven output
        next_s.irq = |(s.flag & s.mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s         <= '0;
            s.flag[0] <= STAT0_RST[4:0];
            s.flag[1] <= STAT1_RST[4:0];
            s.gra     <= {2{GR_RST}};
            s.grb     <= {2{GR_RST}};
            s.grc     <= {2{GR_RST}};
            s.grd     <= {2{GR_RST}};
        end
        else if (ce)
            s <= next_s;
    end

    // Outputs straight from state flops
    assign prdata  = s.rdata;
    assign pready  = s.rdy;
    assign pslverr = s.err;
    assign pin_b   = s.pb;
    assign pin_c   = s.pc;
    assign pin_d   = s.pd;
    assign irq     = s.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    ext_gate_hold_a: assert property ( // [R1]
        @(posedge pclk) disable iff (!presetn)
        ce && s.css == CSS_EXT && !s.exten && !(acc && pwrite) |=> s.cnt == $past(s.cnt))
        else $error("counter moved with external source disabled");

    flag_a_set_a: assert property ( // [R2]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.cnt[0] == s.gra[0] |=> s.flag[0][SB_A] && s.cnt[0] == 16'h0000)
        else $error("period match did not set flag A");

    flag_b_set_a: assert property ( // [R3]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.cnt[0] == s.grb[0] |=> s.flag[0][SB_B])
        else $error("match B did not set flag B");

    flag_c_buf_a: assert property ( // [R4]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.bfc[0] && s.cnt[0] == s.grc[0] |=> s.flag[0][SB_C])
        else $error("buffered match C did not set flag C");

    ovf_set_a: assert property ( // [R6]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[1] && s.cnt[1] == CNT_MAX && s.gra[1] != CNT_MAX
        |=> s.flag[1][SB_OVF] && s.cnt[1] == 16'h0000)
        else $error("wrap did not set overflow");

    stat_fixed_a: assert property ( // [R11]
        @(posedge pclk) disable iff (!presetn)
        acc && !pwrite && ra == R_STAT && !ch |-> prdata[7:5] == 3'h3)
        else $error("channel 0 status bit 5 not one");

    clear_after_read_a: assert property ( // [R8] [R9]
        @(posedge pclk) disable iff (!presetn)
        $fell(s.flag[0][SB_B]) |-> $past(s.armed[0][SB_B]) && $past(acc && pwrite)
        && $past(ra == R_STAT && !ch && !pwdata[SB_B]))
        else $error("flag cleared without read then zero write");

    one_write_keeps_a: assert property ( // [R10]
        @(posedge pclk) disable iff (!presetn)
        ce && acc && pwrite && ra == R_STAT && !ch && pwdata[SB_A] && s.flag[0][SB_A]
        |=> s.flag[0][SB_A])
        else $error("writing one changed a flag");

    buf_load_a: assert property ( // [R19]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.bfd[0] && s.cnt[0] == s.gra[0] && !(acc && pwrite)
        |=> s.grb[0] == $past(s.grd[0]))
        else $error("buffer D not loaded into B at period match");

    pin_c_quiet_a: assert property ( // [R15]
        @(posedge pclk) disable iff (!presetn)
        s.bfc[0] && $past(s.bfc[0]) && $past(ce) |-> !pin_c[0])
        else $error("buffered C drove its pin");

    flag_d_set_a: assert property ( // [R5]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.cnt[0] == s.grd[0] |=> s.flag[0][SB_D])
        else $error("match D did not set flag D");

    udf_fixed_a: assert property ( // [R7]
        @(posedge pclk) disable iff (!presetn)
        acc && !pwrite && ra == R_STAT && ch |-> prdata[7:5] == 3'h3)
        else $error("channel 1 upper status bits moved");

    pin_d_quiet_a: assert property ( // [R16]
        @(posedge pclk) disable iff (!presetn)
        s.bfd[0] && $past(s.bfd[0]) && $past(ce) |-> !pin_d[0])
        else $error("buffered D drove its pin");

    // Every pin restarts low when the period closes
    pin_period_low_a: assert property ( // [R13] [R14]
        @(posedge pclk) disable iff (!presetn)
        ce && tk && s.start[0] && s.cnt[0] == s.gra[0] |=> !pin_b[0] && !pin_c[0] && !pin_d[0])
        else $error("pins not low at period start");

    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(ce) |-> irq == $past(|(s.flag & s.mask)))
        else $error("interrupt level does not follow flags and mask");

endmodule // dpt_pwm

// *** sim/dual_channel_pwm_timer_flags_tb.sv ***
/*
 * Self-checking bench for the dual channel PWM timer: flags, clearing,
 * buffers, external clock edges, interrupt level and unmapped access.
 * Assumes the APB slave answers in one access cycle while ce is high.
 */
`timescale 1ns/1ps
module dual_channel_pwm_timer_flags_tb;
    import dpt_pkg::*;

    logic        pclk, presetn, ce, psel, penable, pwrite, ext_clk_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, irq;
    logic [1:0]  pin_b, pin_c, pin_d;
    logic [32:0] exp_q[$];
    string       nam_q[$];
    int          fails, compares, cyc, seed, k;
    logic [15:0] v;

    dpt_pwm DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_pin(ext_clk_pin), .pin_b(pin_b), .pin_c(pin_c),
        .pin_d(pin_d), .irq(irq));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #20 pclk = ~pclk;

    // Runs take well under 3000 cycles; 20000 means a hang
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(logic w, logic [9:0] idx, logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read with the expected {pslverr, prdata} noted for the monitor
    task automatic rd(string nm, logic [9:0] idx, logic [32:0] e);
        exp_q.push_back(e);
        nam_q.push_back(nm);
        apb(1'b0, idx, 32'h0);
    endtask

    task automatic run(logic [31:0] ctrl, int n);
        apb(1'b1, IDX_CTRL, ctrl);
        repeat (n) @(posedge pclk);
        apb(1'b1, IDX_CTRL, 32'h0);
    endtask

    // Ext pin pulses, slow enough for the two-flop synchroniser
    task automatic pulse(int n);
        repeat (n)
        begin
            @(posedge pclk) ext_clk_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: each completed read is matched to the oldest note
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", {pslverr, prdata}, 33'h0);
            else
                chk(nam_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; ext_clk_pin = 0;
        fails = 0; compares = 0; cyc = 0; seed = 45010;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;

        // Reset values; unseen set flag survives a zero write
        rd("stat0 reset", IDX_STAT0, {25'h0, STAT0_RST});
        rd("stat1 reset", IDX_STAT1, {25'h0, STAT1_RST});
        // Any status write disarms, so the reset flag counts as unseen
        apb(1'b1, IDX_STAT0, 32'hDF);
        apb(1'b1, IDX_STAT0, 32'h0);
        rd("stat0 unread", IDX_STAT0, {25'h0, 8'h70});
        rd("unmapped", 10'h3FF, {1'b1, 32'h0});
        $display("test reset done");

        // Random register round trips on general register D of channel 1
        for (k = 0; k < 4; k++)
        begin
            v = 16'($random(seed));
            apb(1'b1, IDX_CH1 + OFS_GRD, {16'h0, v});
            rd("grd1 rw", IDX_CH1 + OFS_GRD, {17'h0, v});
        end
        $display("test registers done");

        // Compare flags A to D, then read-then-zero clearing
        apb(1'b1, IDX_CH0 + OFS_GRA, 32'h9);
        apb(1'b1, IDX_CH0 + OFS_GRB, 32'h4);
        apb(1'b1, IDX_CH0 + OFS_GRC, 32'h5);
        apb(1'b1, IDX_CH0 + OFS_GRD, 32'h6);
        run(32'h1, 40);
        rd("stat0 flags", IDX_STAT0, {25'h0, 8'h7F});
        apb(1'b1, IDX_STAT0, 32'hDF);
        rd("stat0 after ones", IDX_STAT0, {25'h0, 8'h7F});
        apb(1'b1, IDX_STAT0, 32'h0);
        rd("stat0 cleared", IDX_STAT0, {25'h0, 8'h60});
        rd("stat1 untouched", IDX_STAT1, {25'h0, 8'h60});
        $display("test flags done");

        // Buffer mode: C loads period, D loads B changing point
        apb(1'b1, IDX_PINM, 32'h77);
        apb(1'b1, IDX_MODE, 32'h5);
        apb(1'b1, IDX_CH0 + OFS_GRC, 32'h3);
        apb(1'b1, IDX_CH0 + OFS_GRD, 32'h2);
        run(32'h1, 40);
        rd("gra0 loaded", IDX_CH0 + OFS_GRA, {17'h0, 16'h3});
        rd("grb0 loaded", IDX_CH0 + OFS_GRB, {17'h0, 16'h2});
        rd("stat0 buffered", IDX_STAT0, {25'h0, 8'h6F});
        $display("test buffers done");

        // Overflow on channel 1 with interrupt level
        apb(1'b1, IDX_CH1 + OFS_GRA, 32'h4);
        apb(1'b1, IDX_CH1 + OFS_GRB, 32'h100);
        apb(1'b1, IDX_CH1 + OFS_GRC, 32'h100);
        apb(1'b1, IDX_CH1 + OFS_GRD, 32'h100);
        apb(1'b1, IDX_CH1 + OFS_CNT, 32'hFFF0);
        run(32'h2, 40);
        rd("stat1 ovf", IDX_STAT1, {25'h0, 8'h71});
        chk("irq masked", {32'h0, irq}, 33'h0);
        apb(1'b1, IDX_CH1 + OFS_MASK, 32'h10);
        repeat (2) @(posedge pclk);
        chk("irq raised", {32'h0, irq}, 33'h1);
        apb(1'b1, IDX_STAT1, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq cleared", {32'h0, irq}, 33'h0);
        $display("test overflow done");

        // External clock: rise, fall and both edges on channel 1
        apb(1'b1, IDX_CH1 + OFS_GRA, 32'hFFFF);
        for (k = 0; k < 3; k++)
        begin
            apb(1'b1, IDX_CH1 + OFS_CNT, 32'h0);
            apb(1'b1, IDX_CTRL, 32'h96 | (k << CF_EDGE));
            pulse(3);
            repeat (4) @(posedge pclk);
            rd("ext count", IDX_CH1 + OFS_CNT, (k == 2) ? 33'h6 : 33'h3);
        end
        // Edge select is dead while the pin input is disabled
        apb(1'b1, IDX_CH1 + OFS_CNT, 32'h0);
        apb(1'b1, IDX_CTRL, 32'h16);
        pulse(2);
        rd("ext gated", IDX_CH1 + OFS_CNT, 33'h0);
        apb(1'b1, IDX_CTRL, 32'h0);
        $display("test ext clock done");

        // Pin levels on channel 0, stepped by exact external ticks
        apb(1'b1, IDX_MODE, 32'h0);
        apb(1'b1, IDX_CH0 + OFS_CNT, 32'h0);
        apb(1'b1, IDX_CH0 + OFS_GRA, 32'h6);
        apb(1'b1, IDX_CH0 + OFS_GRB, 32'h2);
        apb(1'b1, IDX_CH0 + OFS_GRC, 32'h4);
        apb(1'b1, IDX_CH0 + OFS_GRD, 32'h3);
        apb(1'b1, IDX_CTRL, 32'h95);
        pulse(4);
        repeat (4) @(posedge pclk);
        chk("pins after B and D", {27'h0, pin_d, pin_c, pin_b}, 33'h11);
        // Pulses while ce is low must leave every flop alone
        ce <= 1'b0;
        pulse(2);
        ce <= 1'b1;
        chk("pins frozen", {27'h0, pin_d, pin_c, pin_b}, 33'h11);
        pulse(3);
        repeat (4) @(posedge pclk);
        chk("pins period end", {27'h0, pin_d, pin_c, pin_b}, 33'h0);
        apb(1'b1, IDX_CTRL, 32'h0);
        $display("test pins done");

        @(posedge pclk);
        summarize();
    end
endmodule // dual_channel_pwm_timer_flags_tb
